/* design/vecr_pkg.sv */
`default_nettype none
package vecr_pkg;

  // sub-addresses of the write-only command registers
  localparam logic [7:0] CMD0_OFFSET = 8'h02;
  localparam logic [7:0] LUMA_OFFSET = 8'h03;

  // command register zero field positions
  localparam int SYNC_ADD_BIT = 6;
  localparam int FIELD_POL_BIT = 5;
  localparam int TRAP_BIT = 4;
  localparam int BAR_BIT = 3;
  localparam int LEVEL_MSB = 2;
  localparam int LEVEL_LSB = 1;
  localparam int RATIO_BIT = 0;
  localparam int CMD0_W = 7;

  // luma level register field
  localparam int LUMA_CODE_MSB = 3;
  localparam int LUMA_CODE_LSB = 0;

  // reset values
  localparam logic [6:0] CMD0_RESET = 7'h00;
  localparam logic [3:0] LUMA_RESET = 4'h0;

  // deepest legal attenuation code, 68.75 percent
  localparam logic [3:0] LUMA_CODE_MAX = 4'ha;

  // gains are in 1/32 steps
  localparam logic [5:0] GAIN_UNITY = 6'h20;
  localparam int GAIN_SHIFT = 5;

  typedef enum logic [1:0] {
    LVL_100 = 2'b00,
    LVL_75 = 2'b01,
    LVL_50 = 2'b10,
    LVL_25 = 2'b11
  } vecr_level_e;

  function automatic logic [5:0] levelGain(input logic [1:0] lvl);
    unique case (vecr_level_e'(lvl))
      LVL_100: levelGain = 6'h20;
      LVL_75: levelGain = 6'h18;
      LVL_50: levelGain = 6'h10;
      LVL_25: levelGain = 6'h08;
    endcase
  endfunction : levelGain

  // one code is one 1/32 step below unity
  function automatic logic [5:0] lumaGain(input logic [3:0] code);
    lumaGain = GAIN_UNITY - {2'b00, code};
  endfunction : lumaGain

  function automatic logic [3:0] clampCode(input logic [3:0] code);
    clampCode = (code > LUMA_CODE_MAX) ? LUMA_CODE_MAX : code;
  endfunction : clampCode

  // bars in falling luminance: white, yellow, cyan, green, magenta, red, blue, black
  function automatic logic [7:0] barLuma(input logic [2:0] idx);
    unique case (idx)
      3'h0: barLuma = 8'heb;
      3'h1: barLuma = 8'hd2;
      3'h2: barLuma = 8'haa;
      3'h3: barLuma = 8'h91;
      3'h4: barLuma = 8'h6a;
      3'h5: barLuma = 8'h51;
      3'h6: barLuma = 8'h29;
      3'h7: barLuma = 8'h10;
    endcase
  endfunction : barLuma

endpackage : vecr_pkg
`default_nettype wire

/* design/vecr_scaler.sv */
`timescale 1ns/10ps
`default_nettype none
module vecr_scaler
  import vecr_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // sample and gain in 1/32 steps
  input wire logic [DATA_W-1:0] sampleIn,
  input wire logic [5:0] gainIn,
  // scaled sample, registered
  output logic [DATA_W-1:0] sampleOut
);

  logic [DATA_W+5:0] product;
  logic [DATA_W-1:0] sample_ff;

  // truncation rounds down; unity gain passes the sample exactly
  assign product = sampleIn * gainIn;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_ff <= '0;
    end else if (clkEn) begin
      sample_ff <= product[DATA_W+GAIN_SHIFT-1:GAIN_SHIFT];
    end
  end

  assign sampleOut = sample_ff;

endmodule : vecr_scaler
`default_nettype wire

/* design/vecr_command_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module vecr_command_regs
  import vecr_pkg::*;
#(
  parameter logic [8:0] SYNC_LIFT = 9'h040
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // register write port from host interface
  input wire logic regWrEn,
  input wire logic [7:0] regSubAddr,
  input wire logic [7:0] regWrData,
  // from mode register one
  input wire logic outputFormatSelect,
  // video timing and data
  input wire logic fieldOdd,
  input wire logic compositeSyncLow,
  input wire logic [7:0] lumaIn,
  input wire logic overlayActive,
  input wire logic [7:0] overlayLuma,
  input wire logic [2:0] barIndex,
  input wire logic [7:0] greenIn,
  // video out
  output logic [7:0] lumaOut,
  output logic [8:0] greenOut,
  output logic fieldIndicatorOut,
  // controls to downstream filters
  output logic trapFilterOn,
  output logic chromaRatio411
);

  logic [CMD0_W-1:0] cmd0_ff;
  logic [3:0] lumaCode_ff;
  logic [8:0] greenOut_ff;
  logic fieldOut_ff;
  logic [8:0] nxt_green;
  logic [7:0] srcSample;
  logic [5:0] srcGain;
  logic cmd0Wr;
  logic lumaWr;

  assign cmd0Wr = regWrEn && (regSubAddr == CMD0_OFFSET);
  assign lumaWr = regWrEn && (regSubAddr == LUMA_OFFSET);

  // bit 7 has no function and is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd0_ff <= CMD0_RESET;
    end else if (clkEn && cmd0Wr) begin
      cmd0_ff <= regWrData[CMD0_W-1:0];
    end
  end

  // stored already clamped so the gain never goes below the deepest step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lumaCode_ff <= LUMA_RESET;
    end else if (clkEn && lumaWr) begin
      lumaCode_ff <= clampCode(regWrData[LUMA_CODE_MSB:LUMA_CODE_LSB]);
    end
  end

  // bars beat overlay, overlay beats picture
  always_comb begin
    srcSample = lumaIn;
    srcGain = lumaGain(lumaCode_ff);
    if (cmd0_ff[BAR_BIT]) begin
      srcSample = barLuma(barIndex);
      srcGain = levelGain(cmd0_ff[LEVEL_MSB:LEVEL_LSB]);
    end else if (overlayActive) begin
      srcSample = overlayLuma;
      srcGain = levelGain(cmd0_ff[LEVEL_MSB:LEVEL_LSB]);
    end
  end

  vecr_scaler #(
    .DATA_W(8)
  ) i_vecr_scaler (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .sampleIn(srcSample),
    .gainIn(srcGain),
    .sampleOut(lumaOut)
  );

  // sync tip sits at zero, picture is lifted above it
  always_comb begin
    nxt_green = {1'b0, greenIn};
    if (outputFormatSelect && cmd0_ff[SYNC_ADD_BIT]) begin
      nxt_green = compositeSyncLow ? ({1'b0, greenIn} + SYNC_LIFT) : 9'h000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      greenOut_ff <= 9'h000;
    end else if (clkEn) begin
      greenOut_ff <= nxt_green;
    end
  end

  // registered to keep the field flag aligned with the scaled luma
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fieldOut_ff <= 1'b0;
    end else if (clkEn) begin
      fieldOut_ff <= fieldOdd ^ cmd0_ff[FIELD_POL_BIT];
    end
  end

  assign greenOut = greenOut_ff;
  assign fieldIndicatorOut = fieldOut_ff;
  assign trapFilterOn = cmd0_ff[TRAP_BIT];
  assign chromaRatio411 = cmd0_ff[RATIO_BIT];

  AST_SYNC_TIP: assert property (@(posedge clk) disable iff (rst)
    clkEn && outputFormatSelect && cmd0_ff[SYNC_ADD_BIT] && !compositeSyncLow
    |=> greenOut == 9'h000)
    else $error("sync tip not inserted on green");

  AST_SYNC_LIFT: assert property (@(posedge clk) disable iff (rst)
    clkEn && outputFormatSelect && cmd0_ff[SYNC_ADD_BIT] && compositeSyncLow
    |=> greenOut == {1'b0, $past(greenIn)} + SYNC_LIFT)
    else $error("green not lifted above sync");

  AST_NO_SYNC_SVIDEO: assert property (@(posedge clk) disable iff (rst)
    clkEn && !outputFormatSelect |=> greenOut == {1'b0, $past(greenIn)})
    else $error("green altered outside rgb output");

  AST_FIELD_POL: assert property (@(posedge clk) disable iff (rst)
    clkEn && !cmd0_ff[FIELD_POL_BIT] ##1 clkEn && cmd0_ff[FIELD_POL_BIT] && !cmd0Wr
    |=> fieldIndicatorOut !=
      ($past(fieldIndicatorOut) ^ ($past(fieldOdd) != $past(fieldOdd, 2))))
    else $error("field polarity not inverted");

  // flipped polarity: odd shows low, even shows high
  AST_FIELD_INV: assert property (@(posedge clk) disable iff (rst)
    clkEn && cmd0_ff[FIELD_POL_BIT] |=> fieldIndicatorOut == !$past(fieldOdd))
    else $error("field flag not inverted");

  AST_FIELD_ODD_HIGH: assert property (@(posedge clk) disable iff (rst)
    clkEn && !cmd0_ff[FIELD_POL_BIT] && fieldOdd |=> fieldIndicatorOut)
    else $error("odd field not shown high");

  AST_TRAP_WRITE: assert property (@(posedge clk) disable iff (rst)
    clkEn && cmd0Wr |=> trapFilterOn == $past(regWrData[TRAP_BIT]))
    else $error("trap enable did not follow write");

  AST_BAR_FULL: assert property (@(posedge clk) disable iff (rst)
    clkEn && cmd0_ff[BAR_BIT] && cmd0_ff[LEVEL_MSB:LEVEL_LSB] == 2'b00
    |=> lumaOut == barLuma($past(barIndex)))
    else $error("bar level wrong at full scale");

  AST_BAR_QUARTER: assert property (@(posedge clk) disable iff (rst)
    clkEn && cmd0_ff[BAR_BIT] && cmd0_ff[LEVEL_MSB:LEVEL_LSB] == 2'b11
    |=> lumaOut == (barLuma($past(barIndex)) >> 2))
    else $error("bar level wrong at quarter scale");

  AST_OVERLAY_FULL: assert property (@(posedge clk) disable iff (rst)
    clkEn && !cmd0_ff[BAR_BIT] && overlayActive && cmd0_ff[LEVEL_MSB:LEVEL_LSB] == 2'b00
    |=> lumaOut == $past(overlayLuma))
    else $error("overlay level wrong at full scale");

  AST_OVERLAY_HALF: assert property (@(posedge clk) disable iff (rst)
    clkEn && !cmd0_ff[BAR_BIT] && overlayActive && cmd0_ff[LEVEL_MSB:LEVEL_LSB] == 2'b10
    |=> lumaOut == {1'b0, $past(overlayLuma[7:1])})
    else $error("overlay level wrong at half scale");

  AST_RATIO_WRITE: assert property (@(posedge clk) disable iff (rst)
    clkEn && cmd0Wr ##1 !(clkEn && cmd0Wr) |-> chromaRatio411 == $past(regWrData[RATIO_BIT]))
    else $error("sampling ratio did not follow write");

  AST_LUMA_UNITY: assert property (@(posedge clk) disable iff (rst)
    clkEn && !cmd0_ff[BAR_BIT] && !overlayActive && lumaCode_ff == 4'h0
    |=> lumaOut == $past(lumaIn))
    else $error("unity luma code altered picture");

  // deepest step is 22/32; floor keeps the result inside eight bits
  AST_LUMA_DEEPEST: assert property (@(posedge clk) disable iff (rst)
    clkEn && !cmd0_ff[BAR_BIT] && !overlayActive && lumaCode_ff == LUMA_CODE_MAX
    |=> 16'(lumaOut) == ((16'($past(lumaIn)) * 16'h0016) >> 5))
    else $error("deepest luma step wrong");

  // only a taken write may move the filter controls
  AST_CTRL_HOLD: assert property (@(posedge clk) disable iff (rst)
    !(clkEn && cmd0Wr) |=> $stable(trapFilterOn) && $stable(chromaRatio411))
    else $error("filter control moved without a write");

  AST_CODE_RANGE: assert property (@(posedge clk) disable iff (rst)
    lumaCode_ff <= LUMA_CODE_MAX)
    else $error("stored luma code beyond deepest step");

  AST_LUMA_CLAMP: assert property (@(posedge clk) disable iff (rst)
    clkEn && lumaWr && regWrData[LUMA_CODE_MSB:LUMA_CODE_LSB] > LUMA_CODE_MAX
    |=> lumaCode_ff == LUMA_CODE_MAX)
    else $error("luma code not clamped");

  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    !clkEn |=> $stable(lumaOut) && $stable(greenOut) && $stable(cmd0_ff)
      && $stable(fieldIndicatorOut) && $stable(lumaCode_ff))
    else $error("state moved with clock enable low");

  COV_BARS: cover property (@(posedge clk) disable iff (rst)
    clkEn && cmd0_ff[BAR_BIT] && barIndex == 3'h7);
  COV_SYNC: cover property (@(posedge clk) disable iff (rst)
    clkEn && outputFormatSelect && cmd0_ff[SYNC_ADD_BIT] && !compositeSyncLow);
  COV_CLAMP: cover property (@(posedge clk) disable iff (rst)
    clkEn && lumaWr && regWrData[LUMA_CODE_MSB:LUMA_CODE_LSB] == 4'hf);
  COV_OVERLAY: cover property (@(posedge clk) disable iff (rst)
    clkEn && !cmd0_ff[BAR_BIT] && overlayActive && cmd0_ff[LEVEL_MSB:LEVEL_LSB] == 2'b01);
  COV_FIELD_INV: cover property (@(posedge clk) disable iff (rst)
    clkEn && cmd0_ff[FIELD_POL_BIT] && fieldOdd);

endmodule : vecr_command_regs
`default_nettype wire

/* testbench/vecr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module vecr_host_model (
  // clock
  input wire logic clk,
  // register write port
  output logic regWrEn,
  output logic [7:0] regSubAddr,
  output logic [7:0] regWrData
);
  initial begin
    regWrEn = 1'b0;
    regSubAddr = 8'h00;
    regWrData = 8'h00;
  end
  // one whole byte per strobe; registers are write only
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrEn = 1'b1;
    regSubAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'b0;
    // idle bus must not show a stale value
    regSubAddr = ~a;
    regWrData = ~d;
  endtask : write
endmodule : vecr_host_model
`default_nettype wire

/* testbench/video_encoder_command_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
module video_encoder_command_regs_test;
  import vecr_pkg::*;
  localparam logic [8:0] LIFT = 9'h040;
  logic clk, rst, clkEn, regWrEn, outputFormatSelect, fieldOdd;
  logic compositeSyncLow, overlayActive, fieldIndicatorOut, trapFilterOn, chromaRatio411;
  logic [7:0] regSubAddr, regWrData, lumaIn, overlayLuma, greenIn, lumaOut, d;
  logic [2:0] barIndex;
  logic [8:0] greenOut;
  logic [6:0] c0;
  logic [3:0] c1;
  logic [7:0] barTab [8] = '{8'heb, 8'hd2, 8'haa, 8'h91, 8'h6a, 8'h51, 8'h29, 8'h10};
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  vecr_command_regs #(.SYNC_LIFT(LIFT)) i_vecr_command_regs (.clk(clk), .rst(rst),
    .clkEn(clkEn), .regWrEn(regWrEn), .regSubAddr(regSubAddr), .regWrData(regWrData),
    .outputFormatSelect(outputFormatSelect), .fieldOdd(fieldOdd),
    .compositeSyncLow(compositeSyncLow), .lumaIn(lumaIn), .overlayActive(overlayActive),
    .overlayLuma(overlayLuma), .barIndex(barIndex), .greenIn(greenIn), .lumaOut(lumaOut),
    .greenOut(greenOut), .fieldIndicatorOut(fieldIndicatorOut),
    .trapFilterOn(trapFilterOn), .chromaRatio411(chromaRatio411));
  vecr_host_model i_vecr_host_model (.clk(clk), .regWrEn(regWrEn),
    .regSubAddr(regSubAddr), .regWrData(regWrData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] expLuma();
    int v;
    int g;
    v = c0[3] ? barTab[barIndex] : overlayActive ? overlayLuma : lumaIn;
    g = c0[3] | overlayActive ? 32 - 8 * c0[2:1] : 32 - (c1 > 4'ha ? 10 : c1);
    expLuma = 8'(v * g / 32);
  endfunction : expLuma

  function automatic logic [8:0] expGreen();
    if (!(outputFormatSelect && c0[6])) return {1'b0, greenIn};
    expGreen = compositeSyncLow ? {1'b0, greenIn} + LIFT : 9'h000;
  endfunction : expGreen

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // a disabled clock drops the write, so the shadow stays put
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic en);
    @(negedge clk);
    clkEn = en;
    i_vecr_host_model.write(a, v);
    clkEn = 1'b1;
    if (en && a == 8'h02) c0 = v[6:0];
    if (en && a == 8'h03) c1 = v[3:0];
  endtask : wr

  task automatic pix();
    @(negedge clk);
    {fieldOdd, compositeSyncLow, overlayActive, outputFormatSelect} = 4'($urandom);
    lumaIn = 8'($urandom);
    overlayLuma = 8'($urandom);
    barIndex = 3'($urandom);
    greenIn = 8'($urandom);
    @(negedge clk);
    check(lumaOut, expLuma());
    check(greenOut, expGreen());
    check(fieldIndicatorOut, fieldOdd ^ c0[5]);
    check({trapFilterOn, chromaRatio411}, {c0[4], c0[0]});
  endtask : pix

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    void'($urandom(31));
    {rst, clkEn, outputFormatSelect, fieldOdd, compositeSyncLow, overlayActive} = 6'h31;
    {lumaIn, overlayLuma, greenIn, barIndex, c0, c1} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({lumaOut, greenOut, fieldIndicatorOut, trapFilterOn, chromaRatio411}, '0);
    rst = 1'b0;
    repeat (2) pix();
    // every level code and every luma code, the clamped ones too
    for (int i = 0; i < 16; i++) begin
      wr(8'h03, {4'($urandom), 4'(i)}, 1'b1);
      d = {5'($urandom), 2'(i), 1'($urandom)};
      d[3] = i < 4;
      wr(8'h02, d, 1'b1);
      repeat (2) pix();
    end
    // reset in mid-run must bring every register back to its default
    @(negedge clk);
    rst = 1'b1;
    {c0, c1} = '0;
    @(negedge clk);
    check({lumaOut, greenOut, fieldIndicatorOut, trapFilterOn, chromaRatio411}, '0);
    rst = 1'b0;
    repeat (2) pix();
    // stray sub-addresses and disabled clock mixed in
    for (int i = 0; i < 300; i++) begin
      wr(8'($urandom_range(1, 4)), 8'($urandom), 1'($urandom_range(0, 3) != 0));
      repeat (2) pix();
    end
    summarize();
  end
endmodule : video_encoder_command_regs_test
`default_nettype wire
